// *** verilog/fws_pkg.sv ***
package fws_pkg;
  localparam int FWS_AW = 22;
  localparam int FWS_DW = 8;
  localparam int FWS_PAW = 12;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_ADDR   = 12'h004;
  localparam logic [11:0] OFS_EXPECT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;

  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE  = 1;
  localparam int CTRL_RESET = 2;
  localparam int CTRL_ABORT = 3;

  // status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_READY   = 3;
  localparam int ST_BYTE_LO = 8;

  // status bit positions on the flash data bus
  localparam int BIT_POLL    = 7;
  localparam int BIT_TOGGLE1 = 6;
  localparam int BIT_TIMEOUT = 5;

  localparam logic [7:0] CMD_RESET = 8'hF0;

  localparam logic [FWS_AW-1:0] RST_ADDR   = 22'h000000;
  localparam logic [7:0]        RST_EXPECT = 8'h00;

  // bus timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_READ_NS     = 70;
  localparam int T_WE_NS       = 35;
  localparam int T_GAP_NS      = 20;
  localparam int SYNC_LAT      = 4;
  localparam int RD_CYC  = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC  = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RD_HOLD_LAST = 8'(RD_CYC + SYNC_LAT - 1);
  localparam logic [7:0] WE_LAST      = 8'(WE_CYC - 1);
  localparam logic [7:0] GAP_LAST     = 8'(GAP_CYC - 1);

  typedef enum {ST_IDLE, ST_RD, ST_RD_GAP, ST_EVAL, ST_WR, ST_WR_GAP} fws_state_e;
  typedef enum {SG_FIRST, SG_SECOND, SG_RECHK_A, SG_RECHK_B, SG_FINAL} fws_stage_e;
endpackage

// *** verilog/fws_sync.sv ***
`timescale 1ns/1ns
module fws_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  import fws_pkg::*;

  // three stages per bit; a change is taken once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          s1        <= 1'b1;
          s2        <= 1'b1;
          s3        <= 1'b1;
          o_sync[g] <= 1'b1;
        end else begin
          s1 <= i_async[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            o_sync[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule // fws_sync

// *** verilog/fws_host.sv ***
// Function
// R1: during program, polling bit reads inverse of written bit; true value afterwards.
// R2: polling status is valid after final write strobe rising edge of command.
// R3: host polls a program at the address being programmed.
// R4: program into protected sector shows status about 1 us, then array read.
// R5: polling bit reads 0 while erasing, 1 when done or erase paused.
// R6: host polls sector erase at an address inside a selected sector.
// R7: host polls chip erase at any address in an unprotected sector.
// R8: erase of only protected sectors shows polling activity about 100 us.
// R9: partly protected erase skips protected sectors; status there may be invalid.
// R10: polling bit may settle early; host takes full byte from a later read.
// R11: after seeing timeout flag, host rereads polling bit before declaring failure.
// R12: ready/busy low while programming or erasing, high otherwise.
// R13: toggle bit one inverts on every read cycle while an algorithm runs.
// R14: toggle bit one valid from final write strobe and during erase window.
// R15: protected program toggles about 1 us, protected erase about 100 us.
// R16: toggle bit one stops in erase pause, toggles during paused program.
// R17: toggle bit two toggles at selected erase sectors, active or paused.
// R18: host reads byte twice back to back and compares toggle bit.
// R19: toggling with timeout high: recheck; still toggling means fail and reset.
// R20: host resuming after leaving toggle polling restarts from first double read.
// R21: device sets timeout flag when its internal pulse count limit is exceeded.
// R22: reset command is one write of F0 at any address.
// R23: device toggle bits are flip-flops inverting at the end of each read.
// R24: outside algorithms, reads return array contents on all bits.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module fws_host (
  input  wire logic                         I_REF_CLK,
  input  wire logic                         I_RST_B,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [fws_pkg::FWS_PAW-1:0]  PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  output logic      [fws_pkg::FWS_AW-1:0]   O_FL_ADDR,
  output logic                              O_FL_CE_N,
  output logic                              O_FL_OE_N,
  output logic                              O_FL_WE_N,
  output logic      [fws_pkg::FWS_DW-1:0]   O_FL_DQ,
  output logic                              O_FL_DQ_OE_N,
  input  wire logic [fws_pkg::FWS_DW-1:0]   I_FL_DQ,
  input  wire logic                         I_FL_READY_BUSY_N
);
  import fws_pkg::*;

  fws_state_e            state;
  fws_stage_e            stage;
  logic [7:0]            cnt;
  logic                  mode_toggle;
  logic [FWS_AW-1:0]     valid_status_address;
  logic [7:0]            expect_byte;
  logic                  start_pls;
  logic                  reset_pls;
  logic                  abort_pls;
  logic                  abort_pend;
  logic                  done;
  logic                  fail;
  logic                  rst_after;
  logic [7:0]            rd_byte;
  logic [7:0]            prev_byte;
  logic [FWS_DW-1:0]     dq_sync;
  logic [0:0]            rdy_sync;
  logic                  setup;
  logic                  access;
  logic [31:0]           status_word;

  fws_sync #(.W(FWS_DW + 1)) u_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_b (I_RST_B),
    .i_async ({I_FL_READY_BUSY_N, I_FL_DQ}),
    .o_sync  ({rdy_sync, dq_sync})
  );

  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign status_word = {16'h0000, rd_byte, 4'h0, rdy_sync[0], fail, done,
                        (state != ST_IDLE)}; // R12

  // apb slave: no wait states, answer registered in the setup cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= 1'b0;
      if (setup) begin
        PRDATA <= 32'h00000000;
        if (PADDR == OFS_CTRL) begin
          PRDATA <= {30'h0, mode_toggle, 1'b0};
        end else if (PADDR == OFS_ADDR) begin
          PRDATA <= {10'h000, valid_status_address};
        end else if (PADDR == OFS_EXPECT) begin
          PRDATA <= {24'h000000, expect_byte};
        end else if (PADDR == OFS_STATUS) begin
          PRDATA <= status_word;
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // configuration registers and command pulses
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_toggle          <= 1'b0;
      valid_status_address <= RST_ADDR;
      expect_byte          <= RST_EXPECT;
      start_pls            <= 1'b0;
      reset_pls            <= 1'b0;
      abort_pls            <= 1'b0;
    end else begin
      start_pls <= 1'b0;
      reset_pls <= 1'b0;
      abort_pls <= 1'b0;
      if (access && PWRITE) begin
        if (PADDR == OFS_CTRL) begin
          mode_toggle <= PWDATA[CTRL_MODE];
          start_pls   <= PWDATA[CTRL_START];
          reset_pls   <= PWDATA[CTRL_RESET];
          abort_pls   <= PWDATA[CTRL_ABORT];
        end else if (PADDR == OFS_ADDR) begin
          valid_status_address <= PWDATA[FWS_AW-1:0]; // R3 R6 R7
        end else if (PADDR == OFS_EXPECT) begin
          expect_byte <= PWDATA[7:0];
        end
      end
    end
  end

  // polling sequencer and flash pin drive
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state        <= ST_IDLE;
      stage        <= SG_FIRST;
      cnt          <= 8'h00;
      abort_pend   <= 1'b0;
      done         <= 1'b0;
      fail         <= 1'b0;
      rst_after    <= 1'b0;
      rd_byte      <= 8'h00;
      prev_byte    <= 8'h00;
      O_FL_ADDR    <= RST_ADDR;
      O_FL_CE_N    <= 1'b1;
      O_FL_OE_N    <= 1'b1;
      O_FL_WE_N    <= 1'b1;
      O_FL_DQ      <= 8'h00;
      O_FL_DQ_OE_N <= 1'b1;
    end else begin
      if (abort_pls && state != ST_IDLE) begin
        abort_pend <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          abort_pend <= 1'b0;
          cnt        <= 8'h00;
          if (start_pls) begin
            // each start begins with a fresh first read
            done      <= 1'b0;
            fail      <= 1'b0;
            rst_after <= 1'b0;
            stage     <= SG_FIRST; // R20
            O_FL_ADDR <= valid_status_address; // R3 R6 R7
            O_FL_CE_N <= 1'b0;
            O_FL_OE_N <= 1'b0;
            state     <= ST_RD;
          end else if (reset_pls) begin
            rst_after    <= 1'b0;
            O_FL_DQ      <= CMD_RESET; // R22
            O_FL_DQ_OE_N <= 1'b0;
            O_FL_CE_N    <= 1'b0;
            O_FL_WE_N    <= 1'b0;
            state        <= ST_WR;
          end
        end
        ST_RD: begin
          cnt <= cnt + 8'h01;
          if (cnt == RD_HOLD_LAST) begin
            // rising oe and ce close the read cycle
            prev_byte <= rd_byte;
            rd_byte   <= dq_sync;
            O_FL_CE_N <= 1'b1;
            O_FL_OE_N <= 1'b1;
            cnt       <= 8'h00;
            state     <= ST_RD_GAP;
          end
        end
        ST_RD_GAP: begin
          cnt <= cnt + 8'h01;
          if (cnt == GAP_LAST) begin
            cnt   <= 8'h00;
            state <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state     <= ST_RD;
          O_FL_CE_N <= 1'b0;
          O_FL_OE_N <= 1'b0;
          if (abort_pend) begin
            state     <= ST_IDLE;
            O_FL_CE_N <= 1'b1;
            O_FL_OE_N <= 1'b1;
          end else begin
            case (stage)
              SG_FIRST: begin
                if (mode_toggle) begin
                  stage <= SG_SECOND; // R18
                end else if (rd_byte[BIT_POLL] == expect_byte[BIT_POLL]) begin
                  stage <= SG_FINAL; // R10
                end else if (rd_byte[BIT_TIMEOUT]) begin
                  stage <= SG_RECHK_A; // R11
                end
              end
              SG_SECOND: begin
                if (rd_byte[BIT_TOGGLE1] == prev_byte[BIT_TOGGLE1]) begin
                  stage <= SG_FINAL; // R18
                end else if (rd_byte[BIT_TIMEOUT]) begin
                  stage <= SG_RECHK_A; // R19
                end
              end
              SG_RECHK_A: begin
                if (mode_toggle) begin
                  stage <= SG_RECHK_B; // R19
                end else if (rd_byte[BIT_POLL] == expect_byte[BIT_POLL]) begin
                  stage <= SG_FINAL; // R11
                end else begin
                  rst_after <= 1'b1;
                end
              end
              SG_RECHK_B: begin
                if (rd_byte[BIT_TOGGLE1] == prev_byte[BIT_TOGGLE1]) begin
                  stage <= SG_FINAL; // R19
                end else begin
                  rst_after <= 1'b1;
                end
              end
              default: begin
                // extra read gave settled array data on all bits
                done      <= 1'b1; // R10
                state     <= ST_IDLE;
                O_FL_CE_N <= 1'b1;
                O_FL_OE_N <= 1'b1;
              end
            endcase
          end
          if (!abort_pend && rst_after) begin
            fail <= 1'b1;
          end
        end
        ST_WR: begin
          cnt <= cnt + 8'h01;
          if (cnt == WE_LAST) begin
            O_FL_WE_N <= 1'b1;
            O_FL_CE_N <= 1'b1;
            cnt       <= 8'h00;
            state     <= ST_WR_GAP;
          end
        end
        ST_WR_GAP: begin
          cnt          <= cnt + 8'h01;
          O_FL_DQ_OE_N <= 1'b1;
          if (cnt == GAP_LAST) begin
            cnt   <= 8'h00;
            done  <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // timeout failure: stop polling and issue the reset command
      if (state == ST_EVAL && rst_after && !abort_pend) begin
        rst_after    <= 1'b0;
        fail         <= 1'b1; // R19
        O_FL_DQ      <= CMD_RESET; // R22
        O_FL_DQ_OE_N <= 1'b0;
        O_FL_OE_N    <= 1'b1;
        O_FL_CE_N    <= 1'b0;
        O_FL_WE_N    <= 1'b0;
        cnt          <= 8'h00;
        state        <= ST_WR;
      end
    end
  end
endmodule // fws_host

// *** tb/fws_host_props.sv ***
`timescale 1ns/1ns
module fws_host_props
  import fws_pkg::*;
(
  input wire logic              I_REF_CLK,
  input wire logic              I_RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [FWS_AW-1:0] O_FL_ADDR,
  input wire logic              O_FL_CE_N,
  input wire logic              O_FL_OE_N,
  input wire logic              O_FL_WE_N,
  input wire logic [FWS_DW-1:0] O_FL_DQ,
  input wire logic              O_FL_DQ_OE_N
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_oe; !O_FL_OE_N |-> !O_FL_CE_N; endproperty
  a_oe: assert property (p_oe) else $error("read without select");
  property p_cmd; !O_FL_WE_N |-> O_FL_OE_N && !O_FL_DQ_OE_N && O_FL_DQ == CMD_RESET; endproperty
  a_cmd: assert property (p_cmd) else $error("bad command write");
  property p_rdlen;
    $fell(O_FL_OE_N) |-> (!O_FL_OE_N)[*8] ##1 (!O_FL_OE_N)[*5] ##1 O_FL_OE_N;
  endproperty
  a_rdlen: assert property (p_rdlen) else $error("read length wrong");
  property p_gap; $rose(O_FL_OE_N) |-> O_FL_OE_N[*3]; endproperty
  a_gap: assert property (p_gap) else $error("read gap short");
  property p_welen; $fell(O_FL_WE_N) |-> (!O_FL_WE_N)[*5] ##1 O_FL_WE_N; endproperty
  a_welen: assert property (p_welen) else $error("write pulse length wrong");
  property p_addr; !O_FL_CE_N && !$past(O_FL_CE_N) |-> $stable(O_FL_ADDR); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_dqoe; !O_FL_DQ_OE_N |-> O_FL_OE_N; endproperty
  a_dqoe: assert property (p_dqoe) else $error("drive during read");
endmodule // fws_host_props
bind fws_host fws_host_props u_props (.*);

// *** tb/fws_flash_model.sv ***
`timescale 1ns/1ns
module fws_flash_model
  import fws_pkg::*;
(
  input  wire logic       i_ce_n,
  input  wire logic       i_oe_n,
  input  wire logic       i_we_n,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_load,
  input  wire logic       i_erase,
  input  wire logic       i_to,
  input  wire logic [7:0] i_cnt,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_dq,
  output logic            o_ready_busy_n_out
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] last = 8'h00;
  logic       tgl = 1'b0;
  logic       tgl2 = 1'b0;
  logic       to = 1'b0;
  logic       ers = 1'b0;
  wire        busy = cnt != 8'h00;
  wire        rd = !i_ce_n && !i_oe_n;
  // a load stands for the last write strobe of a command; a short count that
  // ends on unchanged data stands for a protected target
  always @(posedge i_load) begin
    ers = i_erase;
    to = i_to;
    cnt = i_cnt;
  end
  // toggle flips at the end of each read while busy; a timed-out run never finishes
  always @(negedge rd) if (busy) begin
    tgl = ~tgl;
    tgl2 = tgl2 ^ ers;
    if (!to) cnt = cnt - 8'h01;
  end
  always @(posedge i_we_n) if (i_dq == CMD_RESET) begin
    cnt = 8'h00;
    to = 1'b0;
  end
  always @(o_dq) if (rd) last = o_dq;
  // released bus shows the inverse of the last byte
  assign o_dq = !rd ? ~last :
                busy ? {ers ? 1'b0 : ~i_data[7], tgl, to, 2'b00, tgl2, 2'b00} : i_data;
  assign o_ready_busy_n_out = !busy;
endmodule // fws_flash_model

// *** tb/fws_host_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module fws_host_tb;
  import fws_pkg::*;
  logic              clk, rst_b, psel, penable, pwrite, ld, ers, to, err;
  logic              pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, rdy;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [FWS_AW-1:0] fl_addr;
  logic [7:0]        dq_h, dq_m, dq, cnt, dat;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                we_cnt = 0;
  always @(negedge we_n) we_cnt++;
  assign dq = dq_oe_n ? dq_m : dq_h;
  fws_host dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .O_FL_ADDR(fl_addr), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n),
    .O_FL_WE_N(we_n), .O_FL_DQ(dq_h), .O_FL_DQ_OE_N(dq_oe_n), .I_FL_DQ(dq),
    .I_FL_READY_BUSY_N(rdy));
  fws_flash_model u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq),
    .i_load(ld), .i_erase(ers), .i_to(to), .i_cnt(cnt), .i_data(dat), .o_dq(dq_m),
    .o_ready_busy_n_out(rdy));
  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin apb(0, OFS_STATUS, 0); n++; end while (rd[ST_BUSY] !== 1'b0 && n < 400);
    `CHK(rd[ST_BUSY], 1'b0)
  endtask
  task automatic load(input logic e, input logic t, input logic [7:0] c, input logic [7:0] d);
    ers <= e;
    to <= t;
    cnt <= c;
    dat <= d;
    ld <= 1'b1;
    @(posedge clk) ld <= 1'b0;
  endtask
  task automatic t_regs;
    apb(0, OFS_STATUS, 0);
    `CHK(rd, 32'h0000_0008)
    apb(1, OFS_ADDR, 32'h0012_3456);
    apb(0, OFS_ADDR, 0);
    `CHK(rd, 32'h0012_3456)
    apb(1, OFS_EXPECT, 32'h0000_00C3);
    apb(0, OFS_EXPECT, 0);
    `CHK(rd, 32'h0000_00C3)
    apb(1, OFS_CTRL, 32'h0000_0002);
    apb(0, OFS_CTRL, 0);
    `CHK(rd, 32'h0000_0002)
    apb(0, 12'h010, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
  endtask
  task automatic t_ops;
    for (int k = 0; k < 4; k++) begin
      load(k[1], 1'b0, 8'(3 + k), k[1] ? 8'hFF : 8'hA5);
      apb(1, OFS_EXPECT, {24'h0, dat});
      apb(1, OFS_CTRL, {30'h0, k[0], 1'b1});
      apb(0, OFS_STATUS, 0);
      `CHK(rd[ST_READY], 1'b0)
      `CHK(fl_addr, 22'h12_3456)
      wait_idle;
      `CHK({rd[ST_DONE], rd[ST_FAIL]}, 2'b10)
      `CHK(rd[15:8], dat)
    end
  endtask
  task automatic t_to;
    for (int k = 0; k < 2; k++) begin
      load(1'b0, 1'b1, 8'h01, 8'h5A);
      apb(1, OFS_EXPECT, 32'h5A);
      apb(1, OFS_CTRL, {30'h0, k[0], 1'b1});
      wait_idle;
      `CHK(rd[ST_FAIL], 1'b1)
      repeat (8) @(posedge clk);
      apb(0, OFS_STATUS, 0);
      `CHK(rd[ST_READY], 1'b1)
    end
    apb(1, OFS_CTRL, 32'h4);
    wait_idle;
    `CHK(rd[ST_DONE], 1'b1)
    `CHK(we_cnt, 4)
  endtask
  task automatic t_abort;
    load(1'b0, 1'b0, 8'hFF, 8'h3C);
    apb(1, OFS_EXPECT, 32'h3C);
    apb(1, OFS_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    apb(1, OFS_CTRL, 32'h8);
    wait_idle;
    `CHK({rd[ST_DONE], rd[ST_FAIL], ce_n, oe_n}, 4'b0011)
    apb(1, OFS_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK({ce_n, oe_n, we_n, dq_oe_n, fl_addr}, {4'hF, 22'h0})
    apb(0, OFS_STATUS, 0);
    `CHK(rd[2:0], 3'b000)
    apb(1, OFS_CTRL, 32'h4);
    wait_idle;
    repeat (8) @(posedge clk);
    apb(0, OFS_STATUS, 0);
    `CHK(rd[ST_READY], 1'b1)
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
  initial begin
    {rst_b, psel, penable, pwrite, ld, ers, to} = 7'h00;
    {paddr, pwdata, cnt, dat} = 60'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_ops;
    t_abort;
    t_to;
    end_sim;
  end
endmodule // fws_host_tb
